// ===== hw/can_node_cfg.v
// Contract
// RULE1: decode codes 0-6 to seven bit rates
// RULE2: codes 7-15 reserved, no rate assigned
// RULE3: map bit 31 selects custom or default
// RULE4: default mapping uses top N input pins
// RULE5: lowest selected pin drives id bit 0
// RULE6: nibble fields pick pin per id bit
// RULE7: selectors address pins 0 through 15
// RULE8: consult mapping only when pin count nonzero
// RULE9: sample pins once at startup only
// RULE10: pins free for other uses afterward
// RULE11: read-only switch value 0 to 15
// RULE12: switch value undefined without switch fitted
// RULE13: port mode selects multi-purpose port function
// RULE14: one bit per supported mode
// RULE15: supported modes reads fixed 0x61
// RULE16: read-only model number string object
// RULE17: read-only manufacturer string object
// RULE18: with switch: pins<<4 plus switch plus offset
// RULE19: node id clipped to seven bits
// RULE20: bits 8-10 give pin count
// RULE21: rate code read only at reset
`timescale 1ns/1ps
`default_nettype none
`include "node_cfg_defines.vh"

module can_node_cfg #(
	parameter [31:0] MODEL_WORD = 32'h4D4F444C, // arbitrary value
	parameter [31:0] MAKER_WORD = 32'h4D4B5231, // arbitrary value
	parameter HAS_SWITCH = 1
) (
	// clock and reset
	input wire MCLK,
	input wire RST_N,
	// stored configuration and pins
	input wire [15:0] NET_CONFIG,
	input wire [15:0] GPIN,
	input wire [3:0] ADDR_SW,
	// object access
	input wire OBJ_WR,
	input wire OBJ_RD,
	input wire [15:0] OBJ_INDEX,
	input wire [31:0] OBJ_WDATA,
	output reg [31:0] OBJ_RDATA,
	output reg OBJ_ACK,
	output reg OBJ_ERR,
	// results
	output reg [6:0] NODE_ID,
	output reg [31:0] BIT_RATE,
	output reg RATE_VALID,
	output reg CFG_DONE,
	output reg [1:0] PORT_MODE
);
	////////////////////////////////////////////////////////////////////
	localparam ST_LOAD = 1'b0;
	localparam ST_RUN = 1'b1;

	reg state_r;
	reg [31:0] pin_map_r;
	reg [15:0] port_mode_r;
	reg [3:0] sw_r;
	wire [31:0] rate;
	wire rate_ok;
	wire [6:0] mapped;
	wire [2:0] npins;
	wire [6:0] ofs;
	reg [6:0] id_nxt;

	assign npins = NET_CONFIG[`NC_PINS_HI:`NC_PINS_LO]; // RULE20
	assign ofs = NET_CONFIG[`NC_OFS_HI:`NC_OFS_LO];

	rate_decode u_rate (
		.code(NET_CONFIG[`NC_RATE_HI:`NC_RATE_LO]),
		.rate(rate),
		.valid(rate_ok)
	);

	id_mapper u_map (
		.pins(GPIN),
		.pin_map(pin_map_r),
		.npins(npins),
		.value(mapped)
	);

	////////////////////////////////////////////////////////////////////
	// node id sum, truncated to seven bits; offset is added exactly once
	always @* begin
		id_nxt = 7'h00;
		if (npins != 3'h0) begin // RULE8
			id_nxt = mapped;
		end
		if (NET_CONFIG[`NC_SW_BIT] && HAS_SWITCH) begin
			id_nxt = (id_nxt << `SW_SHIFT) + {3'b000, ADDR_SW}; // RULE18
		end
		id_nxt = id_nxt + ofs; // RULE19
	end

	////////////////////////////////////////////////////////////////////
	// one-shot load after reset, then free running
	always @(posedge MCLK) begin
		if (!RST_N) begin
			state_r <= ST_LOAD;
			NODE_ID <= 7'h00;
			BIT_RATE <= `RATE_NONE;
			RATE_VALID <= 1'b0;
			CFG_DONE <= 1'b0;
		end else begin
			case (state_r)
				ST_LOAD: begin
					NODE_ID <= id_nxt; // RULE9
					BIT_RATE <= rate; // RULE21 RULE1
					RATE_VALID <= rate_ok; // RULE2
					CFG_DONE <= 1'b1; // RULE10
					state_r <= ST_RUN;
				end
				default: begin
					state_r <= ST_RUN; // RULE9
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// writable objects and switch sample
	always @(posedge MCLK) begin
		if (!RST_N) begin
			pin_map_r <= `PIN_MAP_RST;
			port_mode_r <= `PORT_MODE_RST;
			PORT_MODE <= 2'b00;
			sw_r <= 4'h0;
		end else begin
			sw_r <= HAS_SWITCH ? ADDR_SW : 4'h0; // RULE11 RULE12
			PORT_MODE <= port_mode_r[1:0]; // RULE13
			if (OBJ_WR && OBJ_INDEX == `IDX_PIN_MAP) begin
				pin_map_r <= OBJ_WDATA & ~`PM_RSV_MASK; // RULE6
			end else if (OBJ_WR && OBJ_INDEX == `IDX_PORT_MODE) begin
				if (OBJ_WDATA[15:0] <= `PORT_MODE_MAX) begin
					port_mode_r <= OBJ_WDATA[15:0]; // RULE13
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// object access answers one cycle later
	always @(posedge MCLK) begin
		if (!RST_N) begin
			OBJ_RDATA <= 32'h00000000;
			OBJ_ACK <= 1'b0;
			OBJ_ERR <= 1'b0;
		end else begin
			OBJ_ACK <= OBJ_RD | OBJ_WR;
			OBJ_ERR <= 1'b0;
			OBJ_RDATA <= 32'h00000000;
			if (OBJ_WR) begin
				if (OBJ_INDEX == `IDX_PORT_MODE) begin
					OBJ_ERR <= OBJ_WDATA[15:0] > `PORT_MODE_MAX;
				end else if (OBJ_INDEX != `IDX_PIN_MAP) begin
					OBJ_ERR <= 1'b1; // read-only or unknown
				end
			end else if (OBJ_RD) begin
				if (OBJ_INDEX == `IDX_SWITCH) begin
					OBJ_RDATA <= {28'h0000000, sw_r}; // RULE11
				end else if (OBJ_INDEX == `IDX_PIN_MAP) begin
					OBJ_RDATA <= pin_map_r;
				end else if (OBJ_INDEX == `IDX_PORT_MODE) begin
					OBJ_RDATA <= {16'h0000, port_mode_r};
				end else if (OBJ_INDEX == `IDX_MODES) begin
					OBJ_RDATA <= `MODES_VALUE; // RULE14 RULE15
				end else if (OBJ_INDEX == `IDX_MODEL) begin
					OBJ_RDATA <= MODEL_WORD; // RULE16
				end else if (OBJ_INDEX == `IDX_MAKER) begin
					OBJ_RDATA <= MAKER_WORD; // RULE17
				end else if (OBJ_INDEX == `IDX_NET_CONFIG) begin
					OBJ_RDATA <= {16'h0000, NET_CONFIG};
				end else begin
					OBJ_ERR <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== hw/id_mapper.v
`timescale 1ns/1ps
`default_nettype none
`include "node_cfg_defines.vh"

module id_mapper (
	// inputs
	input wire [15:0] pins,
	input wire [31:0] pin_map,
	input wire [2:0] npins,
	// mapped pin value
	output reg [6:0] value
);
	integer i;
	reg [4:0] base;
	reg [3:0] sel;
	// pick one pin per id bit with the custom map, or per low npins bit with the default map
	always @* begin
		value = 7'h00;
		base = 5'h10 - {2'b00, npins};
		sel = 4'h0;
		for (i = 0; i < `ID_W; i = i + 1) begin
			if (pin_map[`PM_EN_BIT]) begin // RULE3
				sel = pin_map[i*`PM_FIELD_W +: `PM_FIELD_W]; // RULE6 RULE7
				value[i] = pins[sel];
			end else if (i < npins) begin
				sel = base[3:0] + i[3:0]; // RULE4 RULE5
				value[i] = pins[sel];
			end
		end
	end
endmodule
`default_nettype wire

// ===== hw/node_cfg_defines.vh
`ifndef NODE_CFG_DEFINES_VH
`define NODE_CFG_DEFINES_VH

// object indices
`define IDX_NET_CONFIG 16'h21B0
`define IDX_PIN_MAP 16'h21B1
`define IDX_SWITCH 16'h2197
`define IDX_PORT_MODE 16'h2241
`define IDX_MODES 16'h6502
`define IDX_MODEL 16'h6503
`define IDX_MAKER 16'h6504

// network configuration fields
`define NC_OFS_LO 0
`define NC_OFS_HI 6
`define NC_PINS_LO 8
`define NC_PINS_HI 10
`define NC_SW_BIT 11
`define NC_RATE_LO 12
`define NC_RATE_HI 15

// pin map fields
`define PM_EN_BIT 31
`define PM_FIELD_W 4
`define PM_RSV_MASK 32'h70000000

// values
`define MODES_VALUE 32'h00000061
`define PORT_MODE_RST 16'h0000
`define PORT_MODE_MAX 16'h0003
`define PIN_MAP_RST 32'h00000000
`define SW_SHIFT 4
`define ID_W 7
`define GPIN_TOP 4'hF

// bit rates
`define RATE_C0 32'd1000000
`define RATE_C1 32'd800000
`define RATE_C2 32'd500000
`define RATE_C3 32'd250000
`define RATE_C4 32'd125000
`define RATE_C5 32'd50000
`define RATE_C6 32'd20000
`define RATE_NONE 32'h00000000

`endif

// ===== hw/rate_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "node_cfg_defines.vh"

module rate_decode (
	// code in
	input wire [3:0] code,
	// decoded rate
	output reg [31:0] rate,
	output reg valid
);
	// reserved codes give no rate
	always @* begin
		valid = 1'b1;
		case (code)
			4'h0: rate = `RATE_C0; // RULE1
			4'h1: rate = `RATE_C1;
			4'h2: rate = `RATE_C2;
			4'h3: rate = `RATE_C3;
			4'h4: rate = `RATE_C4;
			4'h5: rate = `RATE_C5;
			4'h6: rate = `RATE_C6;
			default: begin
				rate = `RATE_NONE; // RULE2
				valid = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

// ===== testbench/can_node_cfg_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module can_node_cfg_checker (
	// clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// object access
	input wire logic [3:0] ADDR_SW,
	input wire logic OBJ_WR,
	input wire logic OBJ_RD,
	input wire logic [15:0] OBJ_INDEX,
	input wire logic [31:0] OBJ_WDATA,
	input wire logic [31:0] OBJ_RDATA,
	input wire logic OBJ_ACK,
	input wire logic OBJ_ERR,
	// results
	input wire logic [6:0] NODE_ID,
	input wire logic [31:0] BIT_RATE,
	input wire logic CFG_DONE,
	input wire logic [1:0] PORT_MODE
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	wire rd_only = OBJ_RD && !OBJ_WR;
	////////////////////////////////////////////////////////////////
	// answers to object requests, and id and rate held after load
	ack_follows_req_a: assert property ((OBJ_RD || OBJ_WR) |=> OBJ_ACK)
		else $error("ack missing after request");
	ack_has_cause_a: assert property (OBJ_ACK |-> $past(OBJ_RD || OBJ_WR))
		else $error("ack without request");
	modes_value_a: assert property (rd_only && OBJ_INDEX == 16'h6502 |=> OBJ_RDATA == 32'h61)
		else $error("supported modes value wrong");
	modes_ro_a: assert property (OBJ_WR && OBJ_INDEX == 16'h6502 |=> OBJ_ERR)
		else $error("write to supported modes accepted");
	mode_bad_a: assert property (OBJ_WR && OBJ_INDEX == 16'h2241 && OBJ_WDATA[15:0] > 16'h3
		|=> OBJ_ERR)
		else $error("bad port mode accepted");
	mode_apply_a: assert property (OBJ_WR && OBJ_INDEX == 16'h2241 && OBJ_WDATA[15:0] < 16'h4
		|-> ##2 PORT_MODE == $past(OBJ_WDATA[1:0], 2))
		else $error("port mode not applied");
	switch_read_a: assert property (rd_only && OBJ_INDEX == 16'h2197
		|=> OBJ_RDATA == {28'h0, $past(ADDR_SW, 2)})
		else $error("switch value wrong");
	id_held_a: assert property ($past(CFG_DONE) |-> $stable(NODE_ID))
		else $error("node id moved after load");
	rate_held_a: assert property ($past(CFG_DONE) |-> $stable(BIT_RATE))
		else $error("bit rate moved after load");
	// main scenarios
	cover property ($rose(CFG_DONE));
	cover property (OBJ_ERR);
	cover property (OBJ_ACK && OBJ_RDATA == 32'h61);
endmodule
bind can_node_cfg can_node_cfg_checker chk (.MCLK(MCLK), .RST_N(RST_N), .ADDR_SW(ADDR_SW),
	.OBJ_WR(OBJ_WR), .OBJ_RD(OBJ_RD), .OBJ_INDEX(OBJ_INDEX), .OBJ_WDATA(OBJ_WDATA),
	.OBJ_RDATA(OBJ_RDATA), .OBJ_ACK(OBJ_ACK), .OBJ_ERR(OBJ_ERR), .NODE_ID(NODE_ID),
	.BIT_RATE(BIT_RATE), .CFG_DONE(CFG_DONE), .PORT_MODE(PORT_MODE));
`default_nettype wire

// ===== testbench/pin_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
module pin_switch_model (
	// clock and commands
	input wire logic mclk,
	input wire logic other_use,
	input wire logic [15:0] pin_set,
	input wire logic [3:0] sw_set,
	// pins and switch
	output logic [15:0] gpin,
	output logic [3:0] addr_sw
);
	// pins toggle every cycle once given other uses
	always_ff @(posedge mclk) begin
		gpin <= other_use ? ~gpin : pin_set;
		addr_sw <= sw_set;
	end
endmodule
`default_nettype wire

// ===== testbench/test_can_node_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module test_can_node_cfg;
	typedef struct packed {
		logic [15:0] nc;
		logic [15:0] pins;
		logic [3:0] sw;
		logic [6:0] id;
		logic [31:0] rate;
	} row_t;
	// config, pins, switch, then expected id and rate
	row_t rows [10] = '{
		'{16'h0005, 16'hFFFF, 4'h3, 7'h05, 32'h000F4240},
		'{16'h0805, 16'hFFFF, 4'h3, 7'h08, 32'h000F4240},
		'{16'h1302, 16'hA000, 4'h0, 7'h07, 32'h000C3500},
		'{16'h2A00, 16'h8000, 4'h9, 7'h29, 32'h0007A120},
		'{16'h4100, 16'h8000, 4'h0, 7'h01, 32'h0001E848},
		'{16'h5010, 16'h0000, 4'h0, 7'h10, 32'h0000C350},
		'{16'h6000, 16'h0000, 4'h0, 7'h00, 32'h00004E20},
		'{16'h7000, 16'h0000, 4'h0, 7'h00, 32'h00000000},
		'{16'hF000, 16'h0000, 4'h0, 7'h00, 32'h00000000},
		'{16'h3F7F, 16'hFFFF, 4'hF, 7'h7E, 32'h0003D090}};
	logic mclk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, busy = 1'b0;
	logic [15:0] nc = 16'h0, idx = 16'h0, pin_set = 16'h0;
	logic [3:0] sw_set = 4'h0;
	logic [31:0] wd = 32'h0;
	wire [15:0] gpin;
	wire [3:0] addr_sw;
	wire [31:0] rdata, rate;
	wire [6:0] id;
	wire [1:0] pm;
	wire ack, err, rv, done;
	int err_total = 0, cmp_count = 0;
	initial forever #4 mclk = ~mclk;
	pin_switch_model far (.mclk(mclk), .other_use(busy), .pin_set(pin_set), .sw_set(sw_set),
		.gpin(gpin), .addr_sw(addr_sw));
	can_node_cfg #(.MAKER_WORD(32'h0BADCAFE)) dut (.MCLK(mclk), .RST_N(rst_n), .NET_CONFIG(nc),
		.GPIN(gpin), .ADDR_SW(addr_sw), .OBJ_WR(wr), .OBJ_RD(rd), .OBJ_INDEX(idx),
		.OBJ_WDATA(wd), .OBJ_RDATA(rdata), .OBJ_ACK(ack), .OBJ_ERR(err), .NODE_ID(id),
		.BIT_RATE(rate), .RATE_VALID(rv), .CFG_DONE(done), .PORT_MODE(pm));
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, got);
			err_total++;
		end
	endtask
	// one object access, answer checked one cycle later
	task obj(input logic w, input logic [15:0] ix, input logic [31:0] d, input logic [31:0] exp,
		input logic e);
		@(posedge mclk);
		wr <= w;
		rd <= !w;
		idx <= ix;
		wd <= d;
		@(posedge mclk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
		chk("ack", 32'h1, {31'h0, ack});
		chk("err", {31'h0, e}, {31'h0, err});
		if (!w) chk("rdata", exp, rdata);
	endtask
	task conclude;
		$display("Checks %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#20000;
		err_total++;
		conclude;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge mclk);
		#1;
		chk("done in reset", 32'h0, {31'h0, done});
		foreach (rows[i]) begin
			@(posedge mclk);
			rst_n <= 1'b0;
			nc <= rows[i].nc;
			pin_set <= rows[i].pins;
			sw_set <= rows[i].sw;
			repeat (2) @(posedge mclk);
			rst_n <= 1'b1;
			repeat (2) @(posedge mclk);
			#1;
			chk("node id", {25'h0, rows[i].id}, {25'h0, id});
			chk("bit rate", rows[i].rate, rate);
			chk("rate valid", {31'h0, rows[i].rate != 0}, {31'h0, rv});
		end
		// pins and switch move after startup
		@(posedge mclk);
		busy <= 1'b1;
		sw_set <= 4'hC;
		repeat (20) @(posedge mclk);
		#1;
		chk("id held", 32'h7E, {25'h0, id});
		obj(1'b0, 16'h6502, 32'h0, 32'h00000061, 1'b0);
		obj(1'b1, 16'h6502, 32'h0, 32'h0, 1'b1);
		obj(1'b0, 16'h2197, 32'h0, 32'h0000000C, 1'b0);
		obj(1'b0, 16'h6504, 32'h0, 32'h0BADCAFE, 1'b0);
		obj(1'b0, 16'h6503, 32'h0, 32'h4D4F444C, 1'b0);
		for (int m = 0; m < 5; m++) begin
			obj(1'b1, 16'h2241, m, 32'h0, m > 3);
			obj(1'b0, 16'h2241, 32'h0, (m > 3) ? 32'h3 : m, 1'b0);
			chk("port mode", (m > 3) ? 32'h3 : m, {30'h0, pm});
		end
		obj(1'b1, 16'h21B1, 32'hFFFFFFFF, 32'h0, 1'b0);
		obj(1'b0, 16'h21B1, 32'h0, 32'h8FFFFFFF, 1'b0);
		obj(1'b1, 16'h1234, 32'h0, 32'h0, 1'b1);
		conclude;
	end
endmodule
`default_nettype wire
